/* File: rtl/ldc_pkg.sv */
// Package for the loop damping configuration register bank.
// Assumes a single 10 MHz reference clock and an 8-bit register port.
`default_nettype none
package ldc_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] LDC_SECOND_DAMP_OFS = 8'h6a;
    localparam logic [7:0] LDC_FIRST_DAMP_OFS  = 8'h6b;
    localparam logic [7:0] LDC_SECOND_DAMP_RST = 8'h13;
    localparam logic [7:0] LDC_FIRST_DAMP_RST  = 8'h14;
    localparam logic [7:0] LDC_WRITE_MASK      = 8'h77;
    localparam int         LDC_DAMP_LSB        = 0;
    localparam int         LDC_GAIN_LSB        = 4;
    // ------------------------------------------------------------------
    // Bandwidth and damping encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LDC_BW_35 = 2'h0,
        LDC_BW_70 = 2'h1,
        LDC_BW_NA = 2'h2,
        LDC_BW_18 = 2'h3
    } ldc_bw_t;
    // Damping factor index: 0=1.2 1=2.5 2=5 3=10 4=20 7=undefined.
    localparam logic [2:0] LDC_DF_1P2 = 3'h0;
    localparam logic [2:0] LDC_DF_2P5 = 3'h1;
    localparam logic [2:0] LDC_DF_5   = 3'h2;
    localparam logic [2:0] LDC_DF_10  = 3'h3;
    localparam logic [2:0] LDC_DF_20  = 3'h4;
    localparam logic [2:0] LDC_DF_BAD = 3'h7;
    // Gain peak in hundredths of a dB.
    localparam logic [5:0] LDC_PK_1P2 = 6'h28;
    localparam logic [5:0] LDC_PK_2P5 = 6'h14;
    localparam logic [5:0] LDC_PK_5   = 6'h0a;
    localparam logic [5:0] LDC_PK_10  = 6'h06;
    localparam logic [5:0] LDC_PK_20  = 6'h03;
endpackage
`default_nettype wire

/* File: rtl/ldc_damp_decode.sv */
// Decodes one damping code against the bandwidth in effect.
// Assumes a registered code and bandwidth; purely combinational.
`default_nettype none
module ldc_damp_decode
    import ldc_pkg::*;
(
    // Inputs
    input  wire logic [2:0] code_i,
    input  wire ldc_bw_t    bw_i,
    // Outputs
    output logic [2:0]      factor_o,
    output logic [5:0]      peak_o
);
    always_comb begin
        unique case (code_i)
            3'h1: factor_o = LDC_DF_1P2;
            3'h2: factor_o = LDC_DF_2P5;
            3'h3: factor_o = LDC_DF_5;
            3'h4: factor_o = (bw_i == LDC_BW_18) ? LDC_DF_5 : LDC_DF_10;
            3'h5: begin
                if (bw_i == LDC_BW_18) begin
                    factor_o = LDC_DF_5;
                end else if (bw_i == LDC_BW_70) begin
                    factor_o = LDC_DF_20;
                end else begin
                    factor_o = LDC_DF_10;
                end
            end
            // Undefined codes are flagged rather than guessed at.
            default: factor_o = LDC_DF_BAD;
        endcase
        unique case (factor_o)
            LDC_DF_1P2: peak_o = LDC_PK_1P2;
            LDC_DF_2P5: peak_o = LDC_PK_2P5;
            LDC_DF_5:   peak_o = LDC_PK_5;
            LDC_DF_10:  peak_o = LDC_PK_10;
            LDC_DF_20:  peak_o = LDC_PK_20;
            default:    peak_o = 6'h00;
        endcase
    end
endmodule
`default_nettype wire

/* File: rtl/ldc_regs.sv */
// Damping configuration registers for two phase-locked loops.
// Assumes a host port already decoded to address, data and write strobes
// on the 10 MHz reference clock; bandwidth and gain enable come from
// neighbouring registers on the same clock.
// Undefined damping codes are stored as written; their decoded factor
// reads as undefined and the peak as zero, so a bad write stays visible.
`default_nettype none
module ldc_regs
    import ldc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,

    // Register port requests
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,

    // Register port answers
    output logic      [7:0] rdata_o,
    output logic            rvalid_o,

    // Loop context
    input  wire ldc_bw_t    first_bw_i,
    input  wire ldc_bw_t    second_bw_i,
    input  wire logic       gain_sel_en_i,

    // Second loop fields
    output logic      [2:0] second_loop_damping_select_o,
    output logic      [2:0] second_loop_detector_analog_gain_o,

    // First loop fields
    output logic      [2:0] first_loop_damping_select_o,
    output logic      [2:0] first_loop_detector_lowfreq_analog_gain_o,
    output logic            first_lowfreq_gain_valid_o,

    // Decoded loop settings
    output logic      [2:0] second_factor_o,
    output logic      [5:0] second_peak_o,
    output logic      [2:0] first_factor_o,
    output logic      [5:0] first_peak_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Both damping registers share one layout: bits 2:0 damping code,
    // bits 6:4 that loop's detector analog gain, bits 7 and 3 unused.
    typedef struct packed {
        logic [7:0] second;
        logic [7:0] first;

        logic [7:0] rdata;
        logic       rvalid;
        logic       lf_valid;

        logic [2:0] f2;
        logic [5:0] p2;
        logic [2:0] f1;
        logic [5:0] p1;
    } ldc_state_t;

    // Reset image: both registers at their power-on values, the read
    // path idle and the decoded settings cleared until the first edge.
    localparam ldc_state_t LDC_STATE_RST = '{
        second:   LDC_SECOND_DAMP_RST,
        first:    LDC_FIRST_DAMP_RST,

        rdata:    8'h00,
        rvalid:   1'b0,
        lf_valid: 1'b0,

        f2:       3'h0,
        p2:       6'h00,
        f1:       3'h0,
        p1:       6'h00
    };

    ldc_state_t s_q;
    ldc_state_t s_d;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic       hit_second_w;
    logic       hit_first_w;

    logic       wr_second_w;
    logic       wr_first_w;
    logic       rd_second_w;
    logic       rd_first_w;

    logic [7:0] wdata_masked_w;
    logic [7:0] rd_word_w;

    assign hit_second_w = (addr_i == LDC_SECOND_DAMP_OFS);
    assign hit_first_w  = (addr_i == LDC_FIRST_DAMP_OFS);
    assign wr_second_w  = wr_i && hit_second_w;
    assign wr_first_w   = wr_i && hit_first_w;
    assign rd_second_w  = rd_i && hit_second_w;
    assign rd_first_w   = rd_i && hit_first_w;

    // Bits 7 and 3 are unused: they are dropped on the way in, so they
    // always read back as zero whatever the host wrote.
    assign wdata_masked_w = wdata_i & LDC_WRITE_MASK;

    // Unmapped addresses read as zero, so a stray read never shows
    // anything but the two damping registers.
    assign rd_word_w = rd_second_w ? s_q.second :
                       rd_first_w  ? s_q.first  :
                                     8'h00;

    // ------------------------------------------------------------------
    // Field view
    // ------------------------------------------------------------------
    logic [2:0] second_code_w;
    logic [2:0] second_gain_w;

    logic [2:0] first_code_w;
    logic [2:0] first_gain_w;

    // The gain fields are passed on unqualified; a separate valid flag
    // tells the first loop whether to use its low-frequency gain, so
    // enabling gain selection later needs no rewrite of this register.
    assign second_code_w = s_q.second[LDC_DAMP_LSB +: 3];
    assign second_gain_w = s_q.second[LDC_GAIN_LSB +: 3];

    assign first_code_w  = s_q.first[LDC_DAMP_LSB +: 3];
    assign first_gain_w  = s_q.first[LDC_GAIN_LSB +: 3];

    // ------------------------------------------------------------------
    // Damping decode
    // ------------------------------------------------------------------
    // The decoded factor and peak are registered again, so they trail a
    // write by two cycles; in return every output leaves a flip-flop.
    logic [2:0] f2_w;
    logic [5:0] p2_w;
    logic [2:0] f1_w;
    logic [5:0] p1_w;

    ldc_damp_decode u_dec2 (
        .code_i   (second_code_w),
        .bw_i     (second_bw_i),
        .factor_o (f2_w),
        .peak_o   (p2_w)
    );

    ldc_damp_decode u_dec1 (
        .code_i   (first_code_w),
        .bw_i     (first_bw_i),
        .factor_o (f1_w),
        .peak_o   (p1_w)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        if (wr_second_w) begin
            s_d.second = wdata_masked_w;
        end

        if (wr_first_w) begin
            s_d.first = wdata_masked_w;
        end

        // A read in the same cycle as a write returns the old value.
        s_d.rvalid = rd_i;
        if (rd_i) begin
            s_d.rdata = rd_word_w;
        end

        // The low-frequency gain is only honoured with selection enabled.
        s_d.lf_valid = gain_sel_en_i;

        s_d.f2 = f2_w;
        s_d.p2 = p2_w;
        s_d.f1 = f1_w;
        s_d.p1 = p1_w;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= LDC_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o  = s_q.rdata;
    assign rvalid_o = s_q.rvalid;

    assign second_loop_damping_select_o       = second_code_w;
    assign second_loop_detector_analog_gain_o = second_gain_w;

    assign first_loop_damping_select_o        = first_code_w;
    assign first_loop_detector_lowfreq_analog_gain_o = first_gain_w;
    assign first_lowfreq_gain_valid_o = s_q.lf_valid;

    assign second_factor_o = s_q.f2;
    assign second_peak_o   = s_q.p2;
    assign first_factor_o  = s_q.f1;
    assign first_peak_o    = s_q.p1;
endmodule
`default_nettype wire

/* File: test/ldc_regs_props.sv */
// Assertions on the damping register port and its fields.
// Assumes binding to ldc_regs; sees only its ports.
`default_nettype none
module ldc_regs_props (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rvalid_o,
    input wire logic       gain_sel_en_i,
    input wire logic       first_lowfreq_gain_valid_o,
    input wire logic [2:0] second_loop_damping_select_o,
    input wire logic [2:0] second_loop_detector_analog_gain_o,
    input wire logic [2:0] first_loop_damping_select_o,
    input wire logic [2:0] first_loop_detector_lowfreq_analog_gain_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sec_w;
    logic [7:0] fst_w;
    assign sec_w = {1'b0, second_loop_detector_analog_gain_o,
                    1'b0, second_loop_damping_select_o};
    assign fst_w = {1'b0, first_loop_detector_lowfreq_analog_gain_o,
                    1'b0, first_loop_damping_select_o};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    chk_wr_second: assert property (wr_i && addr_i == 8'h6a
        |=> sec_w == ($past(wdata_i) & 8'h77)) else $error("6a write");
    chk_wr_first: assert property (wr_i && addr_i == 8'h6b
        |=> fst_w == ($past(wdata_i) & 8'h77)) else $error("6b write");
    chk_keep_second: assert property (!(wr_i && addr_i == 8'h6a)
        |=> $stable(sec_w)) else $error("6a changed");
    chk_keep_first: assert property (!(wr_i && addr_i == 8'h6b)
        |=> $stable(fst_w)) else $error("6b changed");
    chk_rd_second: assert property (rd_i && addr_i == 8'h6a
        |=> rvalid_o && rdata_o == $past(sec_w)) else $error("6a read");
    chk_rd_first: assert property (rd_i && addr_i == 8'h6b
        |=> rvalid_o && rdata_o == $past(fst_w)) else $error("6b read");
    chk_rd_pulse: assert property (!rd_i |=> !rvalid_o)
        else $error("stray read valid");
    chk_lf_valid: assert property (1'b1 |=>
        first_lowfreq_gain_valid_o == $past(gain_sel_en_i))
        else $error("gain valid");
    cover property (wr_i && addr_i == 8'h6b);
    cover property (rvalid_o);
    cover property (first_lowfreq_gain_valid_o);
endmodule
bind ldc_regs ldc_regs_props u_chk (.*);
`default_nettype wire

/* File: test/ldc_host_model.sv */
// Host model driving the register port.
// Assumes one clock; it moves its lines 1 ns after a rising edge.
`default_nettype none
module ldc_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines are inverted so stale values never look valid.
    task write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task read(input logic [7:0] a, output logic v, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        v = rvalid_i;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* File: test/ldc_regs_tb.sv */
// Self-checking bench for the damping register bank.
// Assumes the host model owns the register port lines.
`default_nettype none
module ldc_regs_tb
    import ldc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk_i, rst_i, wr_i, rd_i, gain_sel_en_i, rvalid_o, v;
    logic       first_lowfreq_gain_valid_o;
    logic [7:0] addr_i, wdata_i, rdata_o, r, d;
    logic [2:0] second_loop_damping_select_o, first_loop_damping_select_o;
    logic [2:0] second_loop_detector_analog_gain_o, second_factor_o;
    logic [2:0] first_loop_detector_lowfreq_analog_gain_o, first_factor_o;
    logic [5:0] second_peak_o, first_peak_o;
    logic [7:0] sec_f, fst_f;
    ldc_bw_t    first_bw_i, second_bw_i;
    int         error_cnt, checks_done;
    ldc_bw_t    bws [3] = '{LDC_BW_18, LDC_BW_35, LDC_BW_70};
    logic [2:0] ft [15] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2,
        3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2, 3'h3, 3'h4};
    logic [5:0] pk [5] = '{6'h28, 6'h14, 6'h0a, 6'h06, 6'h03};
    ldc_regs u_dut (.*);
    assign sec_f = {1'b0, second_loop_detector_analog_gain_o, 1'b0,
                    second_loop_damping_select_o};
    assign fst_f = {1'b0, first_loop_detector_lowfreq_analog_gain_o, 1'b0,
                    first_loop_damping_select_o};
    ldc_host_model u_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o),
        .rvalid_i(rvalid_o), .addr_o(addr_i), .wdata_o(wdata_i),
        .wr_o(wr_i), .rd_o(rd_i));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task t_codes;
        for (int c = 1; c < 6; c++) begin
            for (int b = 0; b < 3; b++) begin
                d = {1'b1, 3'(c + b), 1'b1, 3'(c)};
                first_bw_i = bws[b];
                second_bw_i = bws[2 - b];
                u_host.write(8'h6a, d);
                u_host.write(8'h6b, d);
                @(posedge ref_clk_i);
                #1;
                chk(8'(second_factor_o), 8'(ft[c * 3 - b - 1]));
                chk(8'(second_peak_o), 8'(pk[ft[c * 3 - b - 1]]));
                chk(8'(first_factor_o), 8'(ft[c * 3 + b - 3]));
                chk(8'(first_peak_o), 8'(pk[ft[c * 3 + b - 3]]));
                chk(sec_f, d & 8'h77);
                chk(fst_f, d & 8'h77);
                u_host.read(8'h6a, v, r);
                chk(r, d & 8'h77);
                u_host.read(8'h6b, v, r);
                chk(r, d & 8'h77);
            end
        end
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #100000;
        error_cnt++;
        print_verdict;
    end
    task t_reset;
        u_host.read(8'h6a, v, r);
        chk(r, 8'h13);
        u_host.read(8'h6b, v, r);
        chk({7'h00, v}, 8'h01);
        chk(r, 8'h14);
        chk(8'(first_lowfreq_gain_valid_o), 8'h00);
    endtask
    task t_unmapped;
        u_host.write(8'h6c, 8'hff);
        u_host.read(8'h6c, v, r);
        chk(r, 8'h00);
    endtask
    task t_gain;
        gain_sel_en_i = 1'b1;
        first_bw_i = LDC_BW_NA;
        u_host.read(8'h6a, v, r);
        chk(r, 8'h75);
        chk(8'(first_lowfreq_gain_valid_o), 8'h01);
        chk(8'(first_factor_o), 8'(LDC_DF_10));
        chk(8'(first_peak_o), 8'(LDC_PK_10));
    endtask
    initial begin
        rst_i = 1'b1;
        gain_sel_en_i = 1'b0;
        first_bw_i = LDC_BW_35;
        second_bw_i = LDC_BW_35;
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        t_reset;
        t_codes;
        t_unmapped;
        t_gain;
        print_verdict;
    end
endmodule
`default_nettype wire
